// ===== logic/comparator_control_status.sv
// Control and status register block for three analog voltage comparators.
`include "comparator_defines.svh"

module comparator_control_status (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Register port
  input  wire logic [7:0]                 reg_addr,
  input  wire comparator_pkg::reg_byte_t  reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output comparator_pkg::reg_byte_t       reg_rdata,
  // Analog comparison results
  input  wire logic                       third_above_reference,
  input  wire logic                       shared_above_second_negative,
  input  wire logic                       shared_above_first_negative,
  // Analog power-up controls
  output logic                            comparator_one_power,
  output logic                            comparator_two_power,
  output logic                            comparator_three_power,
  // Interrupts
  output logic                            comparator_three_irq_request,
  output logic                            irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  typedef struct packed {
    logic                      irq_enable;
    comparator_pkg::cmp_vec_t  enables;
    comparator_pkg::reg_byte_t rdata;
    logic                      vector_request;
  } ctrl_state_t;

  ctrl_state_t state_r;
  ctrl_state_t state_nxt;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------

  // Shared by the read and write paths so both always agree on the map.
  function automatic comparator_pkg::reg_sel_t decode_offset(input logic [7:0] addr);
    comparator_pkg::reg_sel_t sel;
    sel = comparator_pkg::SEL_NONE;
    case (addr)
      `CSR_OFFSET: begin
        sel = comparator_pkg::SEL_CSR;
      end
      `EVT_STATUS_OFFSET: begin
        sel = comparator_pkg::SEL_EVT_STATUS;
      end
      `EVT_MASK_OFFSET: begin
        sel = comparator_pkg::SEL_EVT_MASK;
      end
      `SETTLED_OFFSET: begin
        sel = comparator_pkg::SEL_SETTLED;
      end
      default: begin
        sel = comparator_pkg::SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // Widens a per-comparator vector into a register byte, upper bits zero.
  function automatic comparator_pkg::reg_byte_t widen(input comparator_pkg::cmp_vec_t v);
    comparator_pkg::reg_byte_t b;
    b = `READ_IDLE;
    b[`EVT_FIRST_NEGATIVE_INPUT] = v[`EVT_FIRST_NEGATIVE_INPUT];
    b[`EVT_SECOND_NEGATIVE_INPUT] = v[`EVT_SECOND_NEGATIVE_INPUT];
    b[`EVT_THIRD_POSITIVE_INPUT] = v[`EVT_THIRD_POSITIVE_INPUT];
    return b;
  endfunction

  comparator_pkg::reg_sel_t wr_sel;
  comparator_pkg::reg_sel_t rd_sel;
  logic                     csr_wr;
  logic                     evt_status_wr;
  logic                     evt_mask_wr;

  assign wr_sel        = reg_wr ? decode_offset(reg_addr) : comparator_pkg::SEL_NONE;
  assign rd_sel        = reg_rd ? decode_offset(reg_addr) : comparator_pkg::SEL_NONE;
  assign csr_wr        = (wr_sel == comparator_pkg::SEL_CSR);
  assign evt_status_wr = (wr_sel == comparator_pkg::SEL_EVT_STATUS);
  assign evt_mask_wr   = (wr_sel == comparator_pkg::SEL_EVT_MASK);

  // --------------------------------------------------------------------------
  // Comparator channels
  // --------------------------------------------------------------------------

  comparator_pkg::cmp_vec_t cmp_status;
  comparator_pkg::cmp_vec_t cmp_rise;
  comparator_pkg::cmp_vec_t cmp_settled;

  // Comparator one: shared positive input against its own negative input.
  comparator_channel u_cmp_one (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .enable     (state_r.enables[`BIT_FIRST_NEGATIVE_INPUT_EN]),
    .latch_mode (1'b0),
    .above      (shared_above_first_negative),
    .status     (cmp_status[`EVT_FIRST_NEGATIVE_INPUT]),
    .rise       (cmp_rise[`EVT_FIRST_NEGATIVE_INPUT]),
    .settled    (cmp_settled[`EVT_FIRST_NEGATIVE_INPUT])
  );

  // Comparator two: shared positive input against its own negative input.
  comparator_channel u_cmp_two (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .enable     (state_r.enables[`BIT_SECOND_NEGATIVE_INPUT_EN]),
    .latch_mode (1'b0),
    .above      (shared_above_second_negative),
    .status     (cmp_status[`EVT_SECOND_NEGATIVE_INPUT]),
    .rise       (cmp_rise[`EVT_SECOND_NEGATIVE_INPUT]),
    .settled    (cmp_settled[`EVT_SECOND_NEGATIVE_INPUT])
  );

  // Comparator three: its own input against the internal reference.
  // The irq enable selects latched mode from the edge that takes its write,
  // so clearing the irq enable returns the bit to the live comparison and drops the vectored request on the same edge.
  comparator_channel u_cmp_three (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .enable     (state_r.enables[`BIT_THIRD_POSITIVE_INPUT_EN]),
    .latch_mode (state_nxt.irq_enable),
    .above      (third_above_reference),
    .status     (cmp_status[`EVT_THIRD_POSITIVE_INPUT]),
    .rise       (cmp_rise[`EVT_THIRD_POSITIVE_INPUT]),
    .settled    (cmp_settled[`EVT_THIRD_POSITIVE_INPUT])
  );

  // --------------------------------------------------------------------------
  // Event flags and summary interrupt
  // --------------------------------------------------------------------------

  comparator_pkg::cmp_vec_t evt_status;
  comparator_pkg::cmp_vec_t evt_mask;
  logic                     evt_irq;

  comparator_events u_events (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .events    (cmp_rise),
    .status_wr (evt_status_wr),
    .mask_wr   (evt_mask_wr),
    .wdata     (reg_wdata[2:0]),
    .status    (evt_status),
    .mask      (evt_mask),
    .irq       (evt_irq)
  );

  // --------------------------------------------------------------------------
  // Register read image
  // --------------------------------------------------------------------------

  comparator_pkg::reg_byte_t csr_image;

  always_comb begin
    csr_image                 = `CSR_RESET;
    csr_image[`BIT_THIRD_POSITIVE_INPUT_OUT]  = cmp_status[`EVT_THIRD_POSITIVE_INPUT];
    csr_image[`BIT_SECOND_NEGATIVE_INPUT_OUT]  = cmp_status[`EVT_SECOND_NEGATIVE_INPUT];
    csr_image[`BIT_FIRST_NEGATIVE_INPUT_OUT]  = cmp_status[`EVT_FIRST_NEGATIVE_INPUT];
    csr_image[`BIT_THIRD_POSITIVE_INPUT_IE]   = state_r.irq_enable;
    csr_image[`BIT_ZERO]      = 1'b0;
    csr_image[`BIT_THIRD_POSITIVE_INPUT_EN]   = state_r.enables[`BIT_THIRD_POSITIVE_INPUT_EN];
    csr_image[`BIT_SECOND_NEGATIVE_INPUT_EN]   = state_r.enables[`BIT_SECOND_NEGATIVE_INPUT_EN];
    csr_image[`BIT_FIRST_NEGATIVE_INPUT_EN]   = state_r.enables[`BIT_FIRST_NEGATIVE_INPUT_EN];
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------

  always_comb begin
    state_nxt = state_r;

    // Status bits and bit 3 are not writable; only control bits take the write.
    if (csr_wr) begin
      state_nxt.irq_enable = reg_wdata[`BIT_THIRD_POSITIVE_INPUT_IE];
      state_nxt.enables    = reg_wdata[`BIT_THIRD_POSITIVE_INPUT_EN:`BIT_FIRST_NEGATIVE_INPUT_EN];
    end

    // Read data stand for exactly one cycle after the strobe; unmapped reads 0.
    case (rd_sel)
      comparator_pkg::SEL_CSR: begin
        state_nxt.rdata = csr_image;
      end
      comparator_pkg::SEL_EVT_STATUS: begin
        state_nxt.rdata = widen(evt_status);
      end
      comparator_pkg::SEL_EVT_MASK: begin
        state_nxt.rdata = widen(evt_mask);
      end
      comparator_pkg::SEL_SETTLED: begin
        // Lets software poll instead of timing the settling delay itself.
        state_nxt.rdata = widen(cmp_settled);
      end
      default: begin
        state_nxt.rdata = `READ_IDLE;
      end
    endcase

    // The vectored request stands while the latched bit is high and enabled.
    state_nxt.vector_request = state_nxt.irq_enable & cmp_status[`EVT_THIRD_POSITIVE_INPUT];
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------

  // No wait or stop input gates anything here: the comparators keep running
  // in both modes, and saving power is left to software clearing the enables.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r.irq_enable     <= 1'b0;
      state_r.enables        <= `EVT_RESET;
      state_r.rdata          <= `READ_IDLE;
      state_r.vector_request <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // Power-up controls only; pin direction stays with the port's own logic,
  // so this block drives no direction or output enable for the shared pins.
  assign comparator_one_power         = state_r.enables[`BIT_FIRST_NEGATIVE_INPUT_EN];
  assign comparator_two_power         = state_r.enables[`BIT_SECOND_NEGATIVE_INPUT_EN];
  assign comparator_three_power       = state_r.enables[`BIT_THIRD_POSITIVE_INPUT_EN];
  assign comparator_three_irq_request = state_r.vector_request;
  assign reg_rdata                    = state_r.rdata;
  assign irq                          = evt_irq;

endmodule

// ===== logic/comparator_defines.svh
// Register offsets, field positions, reset values and timing counts of the comparator block.
`ifndef COMPARATOR_DEFINES_SVH
`define COMPARATOR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CSR_OFFSET        8'h22
`define EVT_STATUS_OFFSET 8'h23
`define EVT_MASK_OFFSET   8'h24
`define SETTLED_OFFSET    8'h25

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSR_RESET         8'h00
`define EVT_RESET         3'h0
`define READ_IDLE         8'h00

// ----------------------------------------------------------------------------
// Control/status register field positions
// ----------------------------------------------------------------------------
`define BIT_THIRD_POSITIVE_INPUT_OUT      7
`define BIT_SECOND_NEGATIVE_INPUT_OUT      6
`define BIT_FIRST_NEGATIVE_INPUT_OUT      5
`define BIT_THIRD_POSITIVE_INPUT_IE       4
`define BIT_ZERO          3
`define BIT_THIRD_POSITIVE_INPUT_EN       2
`define BIT_SECOND_NEGATIVE_INPUT_EN       1
`define BIT_FIRST_NEGATIVE_INPUT_EN       0

// ----------------------------------------------------------------------------
// Event, mask and settled register field positions (one per comparator)
// ----------------------------------------------------------------------------
`define EVT_FIRST_NEGATIVE_INPUT          0
`define EVT_SECOND_NEGATIVE_INPUT          1
`define EVT_THIRD_POSITIVE_INPUT          2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ENABLE_SETTLING_TIME_NS 10000
`define CLK_PERIOD_NS           20
`define SETTLE_CYCLES ((`ENABLE_SETTLING_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W            10

`endif

// ===== logic/comparator_pkg.sv
// Types shared by the comparator control and status logic.
package comparator_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef logic [2:0] cmp_vec_t;

  typedef enum logic [2:0] {
    SEL_NONE       = 3'b000,
    SEL_CSR        = 3'b001,
    SEL_EVT_STATUS = 3'b010,
    SEL_EVT_MASK   = 3'b011,
    SEL_SETTLED    = 3'b100
  } reg_sel_t;

endpackage

// ===== logic/comparator_channel.sv
// One comparator channel: enable gating, optional latching, rise pulse and settling timer.
`include "comparator_defines.svh"

module comparator_channel (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic enable,
  input  wire logic latch_mode,
  // Result of the analog comparison
  input  wire logic above,
  // Status
  output logic      status,
  output logic      rise,
  output logic      settled
);

  typedef struct packed {
    logic                     status;
    logic                     rise;
    logic                     settled;
    logic [`SETTLE_CNT_W-1:0] count;
  } chan_state_t;

  localparam logic [`SETTLE_CNT_W-1:0] SETTLE_LAST = `SETTLE_CNT_W'(`SETTLE_CYCLES - 1);

  chan_state_t state_r;
  chan_state_t state_nxt;
  logic        compare_true;

  always_comb begin
    state_nxt = state_r;
    // A powered-down comparator provides no function, so its comparison never counts as true.
    compare_true = enable & above;
    if (latch_mode) begin
      // Only leaving latched mode while the comparison is false, or reset, drops it.
      state_nxt.status = state_r.status | compare_true;
    end else begin
      state_nxt.status = compare_true;
    end
    state_nxt.rise = state_nxt.status & ~state_r.status;
    if (!enable) begin
      state_nxt.count   = '0;
      state_nxt.settled = 1'b0;
    end else if (!state_r.settled) begin
      if (state_r.count == SETTLE_LAST) begin
        state_nxt.settled = 1'b1;
      end else begin
        state_nxt.count = state_r.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign status  = state_r.status;
  assign rise    = state_r.rise;
  assign settled = state_r.settled;

endmodule

// ===== logic/comparator_events.sv
// Sticky event flags with write-one-to-clear, a mask and one level interrupt.
`include "comparator_defines.svh"

module comparator_events (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Event pulses
  input  wire comparator_pkg::cmp_vec_t  events,
  // Software access
  input  wire logic                      status_wr,
  input  wire logic                      mask_wr,
  input  wire comparator_pkg::cmp_vec_t  wdata,
  // Results
  output comparator_pkg::cmp_vec_t       status,
  output comparator_pkg::cmp_vec_t       mask,
  output logic                           irq
);

  typedef struct packed {
    comparator_pkg::cmp_vec_t status;
    comparator_pkg::cmp_vec_t mask;
    logic                     irq;
  } evt_state_t;

  evt_state_t state_r;
  evt_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // A new event in the clearing cycle survives: the set is applied last.
    if (status_wr) begin
      state_nxt.status = state_r.status & ~wdata;
    end
    state_nxt.status = state_nxt.status | events;
    if (mask_wr) begin
      state_nxt.mask = wdata;
    end
    state_nxt.irq = |(state_nxt.status & state_nxt.mask);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign status = state_r.status;
  assign mask   = state_r.mask;
  assign irq    = state_r.irq;

endmodule

// ===== tb/comparator_control_status_props.sv
// Concurrent checks on the ports of the comparator control and status block.
`include "comparator_defines.svh"

module comparator_control_status_props (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // Register port
  input wire logic [7:0]                reg_addr,
  input wire comparator_pkg::reg_byte_t reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire comparator_pkg::reg_byte_t reg_rdata,
  // Comparison results
  input wire logic                      third_above_reference,
  input wire logic                      shared_above_second_negative,
  input wire logic                      shared_above_first_negative,
  // Power and interrupts
  input wire logic                      comparator_one_power,
  input wire logic                      comparator_two_power,
  input wire logic                      comparator_three_power,
  input wire logic                      comparator_three_irq_request,
  input wire logic                      irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic csr_wr;
  logic csr_rd;
  logic evt_wr;
  assign csr_wr = reg_wr && reg_addr == `CSR_OFFSET;
  assign csr_rd = reg_rd && reg_addr == `CSR_OFFSET;
  assign evt_wr = reg_wr && (reg_addr == `EVT_STATUS_OFFSET || reg_addr == `EVT_MASK_OFFSET);

  chk_one_power_wr: assert property (
    csr_wr |=> comparator_one_power == $past(reg_wdata[`BIT_FIRST_NEGATIVE_INPUT_EN]))
    else $error("comparator one power does not follow the written enable");
  chk_two_power_wr: assert property (
    csr_wr |=> comparator_two_power == $past(reg_wdata[`BIT_SECOND_NEGATIVE_INPUT_EN]))
    else $error("comparator two power does not follow the written enable");
  chk_three_power_wr: assert property (
    csr_wr |=> comparator_three_power == $past(reg_wdata[`BIT_THIRD_POSITIVE_INPUT_EN]))
    else $error("comparator three power does not follow the written enable");
  chk_csr_low_bits: assert property (
    csr_rd |=> reg_rdata[3] == 1'b0 && reg_rdata[2:0] ==
      {comparator_three_power, comparator_two_power, comparator_one_power})
    else $error("control byte low bits read wrong");
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !irq && !comparator_three_irq_request && !comparator_one_power
      && !comparator_two_power && !comparator_three_power && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  chk_cmp_one_live: assert property (
    csr_rd && comparator_one_power && $past(comparator_one_power)
      |=> reg_rdata[5] == $past(shared_above_first_negative, 2))
    else $error("comparator one status does not follow its input");
  chk_cmp_two_live: assert property (
    csr_rd && comparator_two_power && $past(comparator_two_power)
      |=> reg_rdata[6] == $past(shared_above_second_negative, 2))
    else $error("comparator two status does not follow its input");
  chk_request_clear: assert property (
    $fell(comparator_three_irq_request) |-> $past(csr_wr && !reg_wdata[`BIT_THIRD_POSITIVE_INPUT_IE]))
    else $error("latched request dropped without clearing the irq enable");
  chk_irq_clear: assert property (
    $fell(irq) |-> $past(evt_wr, 1) || $past(evt_wr, 2))
    else $error("interrupt dropped without a status or mask write");
  chk_unmapped_zero: assert property (
    reg_rd && (reg_addr < `CSR_OFFSET || reg_addr > `SETTLED_OFFSET) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
endmodule

bind comparator_control_status comparator_control_status_props props_i (.*);

// ===== tb/analog_front_model.sv
// Analog side of the comparators: pin voltages as codes, compared after one cycle.
module analog_front_model #(
  parameter logic [7:0] REFERENCE = 8'hAA
) (
  // Clock
  input  wire logic       clk,
  // Pin voltages, driven directly by the bench
  input  wire logic [7:0] port_d_bit_zero,
  input  wire logic [7:0] port_d_bit_one,
  input  wire logic [7:0] port_d_bit_two,
  input  wire logic [7:0] port_d_bit_three,
  // Comparison results
  output logic            third_above_reference,
  output logic            shared_above_second_negative,
  output logic            shared_above_first_negative
);
  // Equal voltages count as not above, so ties exercise the false side.
  always_ff @(posedge clk) begin
    third_above_reference        <= port_d_bit_zero > REFERENCE;
    shared_above_second_negative <= port_d_bit_two > port_d_bit_three;
    shared_above_first_negative  <= port_d_bit_two > port_d_bit_one;
  end
endmodule

// ===== tb/comparator_control_status_tb.sv
// Self-checking testbench of the comparator control and status block.
`include "comparator_defines.svh"

module comparator_control_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] REF = 8'hAA;
  logic                      clk;
  logic                      sys_rst;
  logic [7:0]                reg_addr;
  comparator_pkg::reg_byte_t reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  comparator_pkg::reg_byte_t reg_rdata;
  logic                      a3, a2, a1, p1, p2, p3, req, irq;
  logic [7:0]                v0, v1, v2, v3;
  comparator_pkg::reg_byte_t got;
  logic [2:0]                en;
  logic [2:0]                ready;
  int                        fails, samples_checked, cycles, seed;

  comparator_control_status comparator_control_status_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .third_above_reference(a3), .shared_above_second_negative(a2),
    .shared_above_first_negative(a1), .comparator_one_power(p1), .comparator_two_power(p2),
    .comparator_three_power(p3), .comparator_three_irq_request(req), .irq(irq));
  analog_front_model #(.REFERENCE(REF)) analog_front_model_i (.clk(clk),
    .port_d_bit_zero(v0), .port_d_bit_one(v1), .port_d_bit_two(v2), .port_d_bit_three(v3),
    .third_above_reference(a3), .shared_above_second_negative(a2),
    .shared_above_first_negative(a1));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input comparator_pkg::reg_byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
  endtask

  task automatic check(input comparator_pkg::reg_byte_t g, input comparator_pkg::reg_byte_t e);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask

  task automatic volts(input logic [7:0] n0, n1, n2, n3);
    @(posedge clk);
    v0 <= n0;
    v1 <= n1;
    v2 <= n2;
    v3 <= n3;
    repeat (3) @(posedge clk);
  endtask

  // Live image: status bits are gated by their enables, irq enable clear.
  function automatic comparator_pkg::reg_byte_t exp_live(input logic [2:0] e,
                                                         input logic [7:0] n0, n1, n2, n3);
    return {e[2] & (n0 > REF), e[1] & (n2 > n3), e[0] & (n2 > n1), 2'b00, e};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    seed = 39593;
    ready = 3'h0;
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0_0000};
    {v0, v1, v2, v3} = 32'h0000_0000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`CSR_OFFSET);
    check(got, 8'h00);
    rd(8'h30);
    check(got, 8'h00);
    wr(`CSR_OFFSET, 8'hFF);
    rd(`CSR_OFFSET);
    check(got, 8'h17);
    $display("test reset_and_access done");
    for (int i = 0; i < 40; i++) begin
      en = 3'($random(seed));
      if (i < 2) volts(REF, 8'h40, 8'h40, 8'h40);
      else volts(8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      wr(`CSR_OFFSET, {5'h00, en});
      rd(`SETTLED_OFFSET);
      check(got, {5'h00, en & ready});
      // Software must not trust an output before its comparator has settled.
      repeat (`SETTLE_CYCLES) @(posedge clk);
      rd(`SETTLED_OFFSET);
      check(got, {5'h00, en});
      ready = en;
      rd(`CSR_OFFSET);
      check(got, exp_live(en, v0, v1, v2, v3));
      check({5'h00, p3, p2, p1}, {5'h00, en});
    end
    $display("test random_live done");
    wr(`CSR_OFFSET, 8'h04);
    repeat (`SETTLE_CYCLES) @(posedge clk);
    rd(`SETTLED_OFFSET);
    check(got, 8'h04);
    volts(8'h10, 8'h00, 8'h00, 8'h00);
    wr(`EVT_STATUS_OFFSET, 8'h07);
    wr(`EVT_MASK_OFFSET, 8'h00);
    wr(`CSR_OFFSET, 8'h14);
    volts(8'hF0, 8'h00, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    check({7'h00, req}, 8'h01);
    volts(8'h10, 8'h00, 8'h00, 8'h00);
    rd(`CSR_OFFSET);
    check(got, 8'h94);
    rd(`EVT_STATUS_OFFSET);
    check(got, 8'h04);
    check({7'h00, irq}, 8'h00);
    wr(`EVT_MASK_OFFSET, 8'h04);
    rd(`EVT_MASK_OFFSET);
    check(got, 8'h04);
    repeat (3) @(posedge clk);
    check({7'h00, irq}, 8'h01);
    wr(`EVT_STATUS_OFFSET, 8'h04);
    repeat (3) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    wr(`CSR_OFFSET, 8'h04);
    repeat (3) @(posedge clk);
    rd(`CSR_OFFSET);
    check(got, 8'h04);
    check({7'h00, req}, 8'h00);
    $display("test latched_interrupt done");
    summarize();
  end
endmodule
